//--- cmpctl_top.sv
// Purpose: control registers, result read-back and edge event logic for three comparators
// Assumes: analog cores supply raw results asynchronously; sfr bus is single-cycle
// Notes: registers sit on pages 1..3 at addresses 0x88 and 0x89
// Function
// - enable bit seven powers each comparator
// - disabled comparator drives crossbar output low
// - bit six reads present comparator result
// - rising output edge sets rise flag
// - falling output edge sets fall flag
// - edge flags stay set until software clears
// - mode register edge enables gate interrupt
// - extended interrupt enable also gates interrupt
// - bits three-two select positive hysteresis
// - bits one-zero select negative hysteresis
// - mode bits one-zero select response time
// - reset: control zero, mode 0x02
// - unused mode bits read zero, ignore writes
// - control 0x88, mode 0x89, pages one-three
// - output fans out to all consumers
`timescale 1ns/1ps
module cmpctl_top
  import cmpctl_pkg::*;
#(
  parameter int unsigned NUM_CMP = CMPCTL_NUM_CMP
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] sfr_page_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  input wire logic [NUM_CMP-1:0] cmp_raw_in,
  input wire logic [NUM_CMP-1:0] ext_irq_cmp_enable_in,
  output logic [NUM_CMP-1:0] cmp_enable_out,
  output logic [NUM_CMP*2-1:0] pos_hyst_select_out,
  output logic [NUM_CMP*2-1:0] neg_hyst_select_out,
  output logic [NUM_CMP*2-1:0] response_mode_select_out,
  output logic [NUM_CMP-1:0] crossbar_cmp_out,
  output logic [NUM_CMP-1:0] reset_cmp_out,
  output logic [NUM_CMP-1:0] cmp_result_state_out,
  output logic [NUM_CMP-1:0] cmp_irq_out
);

  // page numbers are eight bits wide, so at most 254 comparators fit above the base page
  if (NUM_CMP < 1 || NUM_CMP > 254) begin : gen_bad_num_cmp
    $error("cmpctl_top: NUM_CMP out of range");
  end

  // page number that selects comparator idx
  function automatic logic page_hit(input logic [7:0] page, input int unsigned idx);
    logic [7:0] want;
    want = 8'(CMPCTL_PAGE_BASE + idx[7:0]);
    return page == want;
  endfunction

  logic [NUM_CMP-1:0] sync_lvl;
  logic [NUM_CMP-1:0] prev_q, prev_d;
  logic [NUM_CMP-1:0] en_q, en_d;
  logic [NUM_CMP-1:0] rise_q, rise_d;
  logic [NUM_CMP-1:0] fall_q, fall_d;
  logic [1:0] hyp_q [NUM_CMP];
  logic [1:0] hyp_d [NUM_CMP];
  logic [1:0] hyn_q [NUM_CMP];
  logic [1:0] hyn_d [NUM_CMP];
  logic [7:0] mode_q [NUM_CMP];
  logic [7:0] mode_d [NUM_CMP];
  logic [7:0] rdata_q, rdata_d;
  logic [NUM_CMP-1:0] irq_q, irq_d;
  logic [NUM_CMP-1:0] cmp_state;
  logic [NUM_CMP-1:0] rise_evt, fall_evt;
  logic [NUM_CMP-1:0] ctrl_sel, mode_sel;
  logic hit;

  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : gen_sync
      cmpctl_sync u_sync (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .async_in(cmp_raw_in[g]),
        .level_out(sync_lvl[g])
      );
    end
  endgenerate

  // a disabled comparator reads as low so enabling or disabling can itself make an edge;
  // software is expected to ignore events during the power-up time
  always_comb begin
    cmp_state = sync_lvl & en_q;
    prev_d = cmp_state;
    rise_evt = cmp_state & ~prev_q;
    fall_evt = ~cmp_state & prev_q;
  end

  always_comb begin
    ctrl_sel = '0;
    mode_sel = '0;
    hit = 1'b0;
    for (int unsigned i = 0; i < NUM_CMP; i++) begin
      if (page_hit(sfr_page_in, i) && sfr_addr_in == CMPCTL_CTRL_ADDR) begin
        ctrl_sel[i] = 1'b1;
        hit = 1'b1;
      end else if (page_hit(sfr_page_in, i) && sfr_addr_in == CMPCTL_MODE_ADDR) begin
        mode_sel[i] = 1'b1;
        hit = 1'b1;
      end
    end
  end

  always_comb begin
    en_d = en_q;
    rise_d = rise_q;
    fall_d = fall_q;
    for (int unsigned i = 0; i < NUM_CMP; i++) begin
      hyp_d[i] = hyp_q[i];
      hyn_d[i] = hyn_q[i];
      mode_d[i] = mode_q[i];
      if (sfr_wr_in && ctrl_sel[i]) begin
        en_d[i] = sfr_wdata_in[CMPCTL_EN_BIT];
        rise_d[i] = sfr_wdata_in[CMPCTL_RISE_BIT];
        fall_d[i] = sfr_wdata_in[CMPCTL_FALL_BIT];
        hyp_d[i] = sfr_wdata_in[CMPCTL_HYP_LSB +: 2];
        hyn_d[i] = sfr_wdata_in[CMPCTL_HYN_LSB +: 2];
      end
      if (sfr_wr_in && mode_sel[i]) begin
        mode_d[i] = sfr_wdata_in & CMPCTL_MODE_WMASK;
      end
      // hardware set is applied last so it beats a same-cycle clear
      if (rise_evt[i]) begin
        rise_d[i] = 1'b1;
      end
      if (fall_evt[i]) begin
        fall_d[i] = 1'b1;
      end
    end
  end

  always_comb begin
    for (int unsigned i = 0; i < NUM_CMP; i++) begin
      irq_d[i] = ((rise_q[i] & mode_q[i][CMPCTL_RIE_BIT])
               | (fall_q[i] & mode_q[i][CMPCTL_FIE_BIT]))
               & ext_irq_cmp_enable_in[i];
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    for (int unsigned i = 0; i < NUM_CMP; i++) begin
      if (sfr_rd_in && ctrl_sel[i]) begin
        rdata_d = {en_q[i], cmp_state[i], rise_q[i], fall_q[i], hyp_q[i], hyn_q[i]};
      end else if (sfr_rd_in && mode_sel[i]) begin
        rdata_d = mode_q[i] & CMPCTL_MODE_WMASK;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      prev_q <= '0;
      en_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
      irq_q <= '0;
      rdata_q <= 8'h00;
      for (int unsigned i = 0; i < NUM_CMP; i++) begin
        hyp_q[i] <= CMPCTL_CTRL_RESET[CMPCTL_HYP_LSB +: 2];
        hyn_q[i] <= CMPCTL_CTRL_RESET[CMPCTL_HYN_LSB +: 2];
        mode_q[i] <= CMPCTL_MODE_RESET;
      end
    end else begin
      prev_q <= prev_d;
      en_q <= en_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      for (int unsigned i = 0; i < NUM_CMP; i++) begin
        hyp_q[i] <= hyp_d[i];
        hyn_q[i] <= hyn_d[i];
        mode_q[i] <= mode_d[i];
      end
    end
  end

  always_comb begin
    for (int unsigned i = 0; i < NUM_CMP; i++) begin
      pos_hyst_select_out[2*i +: 2] = hyp_q[i];
      neg_hyst_select_out[2*i +: 2] = hyn_q[i];
      response_mode_select_out[2*i +: 2] = mode_q[i][CMPCTL_MD_LSB +: 2];
    end
  end

  assign sfr_rdata_out = rdata_q;
  assign sfr_hit_out = hit;
  assign cmp_enable_out = en_q;
  assign crossbar_cmp_out = cmp_state;
  assign reset_cmp_out = cmp_state;
  assign cmp_result_state_out = cmp_state;
  assign cmp_irq_out = irq_q;
endmodule

//--- cmpctl_pkg.sv
// Purpose: constants and types for the comparator control and edge event block
// Assumes: 8-bit special-function register bus with page select
// Notes: one control and one mode register per comparator, same address on each page
package cmpctl_pkg;
  localparam int unsigned CMPCTL_NUM_CMP = 3;
  localparam logic [7:0] CMPCTL_CTRL_ADDR = 8'h88;
  localparam logic [7:0] CMPCTL_MODE_ADDR = 8'h89;
  localparam logic [7:0] CMPCTL_PAGE_BASE = 8'h01;
  localparam int unsigned CMPCTL_EN_BIT = 7;
  localparam int unsigned CMPCTL_OUT_BIT = 6;
  localparam int unsigned CMPCTL_RISE_BIT = 5;
  localparam int unsigned CMPCTL_FALL_BIT = 4;
  localparam int unsigned CMPCTL_HYP_LSB = 2;
  localparam int unsigned CMPCTL_HYN_LSB = 0;
  localparam int unsigned CMPCTL_RIE_BIT = 5;
  localparam int unsigned CMPCTL_FIE_BIT = 4;
  localparam int unsigned CMPCTL_MD_LSB = 0;
  localparam logic [7:0] CMPCTL_CTRL_RESET = 8'h00;
  localparam logic [7:0] CMPCTL_MODE_RESET = 8'h02;
  localparam logic [7:0] CMPCTL_MODE_WMASK = 8'h33;
  localparam int unsigned CMPCTL_PWRUP_US = 10;
  localparam int unsigned CMPCTL_CLK_MHZ = 25;
  localparam int unsigned CMPCTL_PWRUP_CYCLES = CMPCTL_PWRUP_US * CMPCTL_CLK_MHZ;
  typedef enum logic [1:0] {
    CMPCTL_HYST_OFF,
    CMPCTL_HYST_5MV,
    CMPCTL_HYST_10MV,
    CMPCTL_HYST_20MV
  } cmpctl_hyst_type;
  typedef enum logic [1:0] {
    CMPCTL_RESP_FASTEST,
    CMPCTL_RESP_MODE1,
    CMPCTL_RESP_MODE2,
    CMPCTL_RESP_LOWPOWER
  } cmpctl_resp_type;
endpackage

//--- cmpctl_sync.sv
// Purpose: three-stage synchroniser with agreement filter for one asynchronous level
// Assumes: input changes slowly compared with the clock
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module cmpctl_sync (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic async_in,
  output logic level_out
);
  logic s1_q, s2_q, s3_q, lvl_q;
  logic lvl_d;

  always_comb begin
    lvl_d = lvl_q;
    if (s2_q == s3_q) begin
      lvl_d = s3_q;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_b_in) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;
endmodule

//--- cmpctl_top_monitor.sv
// Purpose: port-level checks of the comparator control block
// Assumes: single clock, synchronous active-low reset
// Notes: per-comparator checks watch comparator 0 on page 1
`timescale 1ns/1ps
module cmpctl_top_monitor
  import cmpctl_pkg::*;
#(parameter int unsigned NUM_CMP = CMPCTL_NUM_CMP) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] sfr_page_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic sfr_hit_out,
  input wire logic [NUM_CMP-1:0] ext_irq_cmp_enable_in,
  input wire logic [NUM_CMP-1:0] cmp_enable_out,
  input wire logic [NUM_CMP*2-1:0] pos_hyst_select_out,
  input wire logic [NUM_CMP*2-1:0] neg_hyst_select_out,
  input wire logic [NUM_CMP*2-1:0] response_mode_select_out,
  input wire logic [NUM_CMP-1:0] crossbar_cmp_out,
  input wire logic [NUM_CMP-1:0] reset_cmp_out,
  input wire logic [NUM_CMP-1:0] cmp_result_state_out,
  input wire logic [NUM_CMP-1:0] cmp_irq_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  sequence ctrl0_wr;
    sfr_wr_in && sfr_page_in == 8'h01 && sfr_addr_in == CMPCTL_CTRL_ADDR;
  endsequence
  sequence mode0_wr;
    sfr_wr_in && sfr_page_in == 8'h01 && sfr_addr_in == CMPCTL_MODE_ADDR;
  endsequence
  sequence ctrl0_rd;
    sfr_rd_in && sfr_page_in == 8'h01 && sfr_addr_in == CMPCTL_CTRL_ADDR;
  endsequence
  sequence mode0_rd;
    sfr_rd_in && sfr_page_in == 8'h01 && sfr_addr_in == CMPCTL_MODE_ADDR;
  endsequence
  enable_write_a: assert property (ctrl0_wr |=> cmp_enable_out[0] == $past(sfr_wdata_in[7]))
    else $error("enable bit not taken");
  hyst_write_a: assert property (ctrl0_wr |=> pos_hyst_select_out[1:0] == $past(sfr_wdata_in[3:2])
    && neg_hyst_select_out[1:0] == $past(sfr_wdata_in[1:0])) else $error("hysteresis fields not taken");
  mode_write_a: assert property (mode0_wr |=> response_mode_select_out[1:0] == $past(sfr_wdata_in[1:0]))
    else $error("response mode not taken");
  off_low_a: assert property ((crossbar_cmp_out & ~cmp_enable_out) == '0)
    else $error("disabled comparator output high");
  fanout_same_a: assert property (reset_cmp_out == crossbar_cmp_out && cmp_result_state_out == crossbar_cmp_out)
    else $error("consumers see different results");
  irq_gate_a: assert property (cmp_irq_out[0] |-> $past(ext_irq_cmp_enable_in[0]))
    else $error("interrupt without extended enable");
  state_read_a: assert property (ctrl0_rd |=> sfr_rdata_out[6] == $past(cmp_result_state_out[0]))
    else $error("result bit differs from state");
  mode_unused_a: assert property (mode0_rd |=> (sfr_rdata_out & 8'hCC) == 8'h00)
    else $error("unused mode bits read nonzero");
  miss_zero_a: assert property (sfr_rd_in && !sfr_hit_out |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read returned data");
endmodule
bind cmpctl_top cmpctl_top_monitor #(.NUM_CMP(NUM_CMP)) u_mon (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .sfr_page_in(sfr_page_in), .sfr_addr_in(sfr_addr_in),
  .sfr_wdata_in(sfr_wdata_in), .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out),
  .sfr_hit_out(sfr_hit_out), .ext_irq_cmp_enable_in(ext_irq_cmp_enable_in), .cmp_enable_out(cmp_enable_out),
  .pos_hyst_select_out(pos_hyst_select_out), .neg_hyst_select_out(neg_hyst_select_out),
  .response_mode_select_out(response_mode_select_out), .crossbar_cmp_out(crossbar_cmp_out),
  .reset_cmp_out(reset_cmp_out), .cmp_result_state_out(cmp_result_state_out), .cmp_irq_out(cmp_irq_out));

//--- test_cmpctl_top.sv
// Purpose: self-checking bench for the comparator control block
// Assumes: inputs change 1 ns after the rising edge
// Notes: rows are {write, page, addr, wdata, expected read}
`timescale 1ns/1ps
module test_cmpctl_top;
  import cmpctl_pkg::*;
  logic core_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [7:0] page, addr, wdata, rdata;
  logic wr, rd, hit;
  logic [2:0] raw, ext, en, xbar, rstc, state, irq;
  logic [5:0] pos, neg, resp;
  int n_mismatch = 0;
  int tests_run = 0;
  localparam logic [32:0] ROWS [11] = '{
    33'h0_01880000, 33'h0_02890002, 33'h0_03880000,
    33'h1_0189FF33, 33'h1_02890000, 33'h1_03892121,
    33'h1_01880F0F, 33'h1_02887636, 33'h1_02880000,
    33'h1_0488FF00, 33'h1_038AFF00};
  cmpctl_top u_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .sfr_page_in(page), .sfr_addr_in(addr),
    .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
    .cmp_raw_in(raw), .ext_irq_cmp_enable_in(ext), .cmp_enable_out(en), .pos_hyst_select_out(pos),
    .neg_hyst_select_out(neg), .response_mode_select_out(resp), .crossbar_cmp_out(xbar),
    .reset_cmp_out(rstc), .cmp_result_state_out(state), .cmp_irq_out(irq));
  always #20 core_clk_in = ~core_clk_in;
  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  // one strobe per access; read data is looked at in the cycle after the strobe
  task automatic sfr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge core_clk_in);
    #1 page = p;
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(posedge core_clk_in);
    #1 wr = 1'b0;
    rd = 1'b0;
  endtask
  task automatic wait_state(input logic v);
    int k;
    k = 0;
    while (state[0] !== v && k < 20) begin
      @(posedge core_clk_in);
      #1 k++;
    end
    if (state[0] !== v) begin
      n_mismatch++;
      print_verdict();
    end
    repeat (2) @(posedge core_clk_in);
    #1;
  endtask
  initial begin
    page = 8'h00; addr = 8'h00; wdata = 8'h00; wr = 1'b0; rd = 1'b0; raw = 3'h0; ext = 3'h1;
    repeat (20) @(posedge core_clk_in);
    #1 rst_b_in = 1'b1;
    foreach (ROWS[i]) begin
      if (ROWS[i][32]) sfr(ROWS[i][31:24], ROWS[i][23:16], ROWS[i][15:8], 1'b1);
      sfr(ROWS[i][31:24], ROWS[i][23:16], 8'h00, 1'b0);
      chk(rdata, ROWS[i][7:0]);
    end
    chk({2'h0, pos}, 8'h03);
    chk({2'h0, neg}, 8'h03);
    chk({2'h0, resp}, 8'h13);
    chk(8'(hit), 8'h00);
    sfr(8'h01, 8'h88, 8'h80, 1'b1);
    chk(8'(en), 8'h01);
    chk(8'(hit), 8'h01);
    chk({2'h0, pos}, 8'h00);
    // the analog core is not trusted until its power-up time has passed
    repeat (CMPCTL_PWRUP_CYCLES) @(posedge core_clk_in);
    #1 raw = 3'h1;
    wait_state(1'b1);
    sfr(8'h01, 8'h88, 8'h00, 1'b0);
    chk(rdata, 8'hE0);
    chk(8'(xbar), 8'h01);
    chk(8'(rstc), 8'h01);
    chk(8'(state), 8'h01);
    sfr(8'h01, 8'h89, 8'h12, 1'b1);
    repeat (2) @(posedge core_clk_in);
    #1 chk(8'(irq), 8'h00);
    sfr(8'h01, 8'h89, 8'h22, 1'b1);
    repeat (2) @(posedge core_clk_in);
    #1 chk(8'(irq), 8'h01);
    ext = 3'h0;
    repeat (2) @(posedge core_clk_in);
    #1 chk(8'(irq), 8'h00);
    ext = 3'h1;
    raw = 3'h0;
    wait_state(1'b0);
    sfr(8'h01, 8'h88, 8'h00, 1'b0);
    chk(rdata, 8'hB0);
    repeat (10) @(posedge core_clk_in);
    sfr(8'h01, 8'h88, 8'h00, 1'b0);
    chk(rdata, 8'hB0);
    sfr(8'h01, 8'h88, 8'h80, 1'b1);
    repeat (2) @(posedge core_clk_in);
    #1 chk(8'(irq), 8'h00);
    // raw rises so that the filtered edge and the clearing write meet at the same clock edge
    raw = 3'h1;
    repeat (3) @(posedge core_clk_in);
    sfr(8'h01, 8'h88, 8'h80, 1'b1);
    sfr(8'h01, 8'h88, 8'h00, 1'b0);
    chk(rdata, 8'hE0);
    sfr(8'h01, 8'h88, 8'h00, 1'b1);
    chk(8'(xbar), 8'h00);
    rst_b_in = 1'b0;
    repeat (4) @(posedge core_clk_in);
    #1 rst_b_in = 1'b1;
    chk({2'h0, resp}, 8'h2A);
    chk(8'(en), 8'h00);
    chk(8'(irq), 8'h00);
    print_verdict();
  end
endmodule
